// ===== hw/pin_select_pkg.sv
package pin_select_pkg;

  // ****************************************************************
  // Bus and register geometry
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SEL_W = 16;
  localparam int NUM_REGS = 8;
  localparam int IDX_W = 3;
  localparam int FIELD_W = 4;
  localparam int FIELDS_PER_REG = 4;
  localparam int NUM_PADS = NUM_REGS * FIELDS_PER_REG;

  // Write-enable half of every written word
  localparam int MASK_LSB = 16;
  localparam logic [SEL_W-1:0] MASK_RESET = 16'h0000;
  localparam logic [SEL_W-1:0] SEL_RESET = 16'h0000;

  // Function code zero routes a pad to general-purpose I/O
  localparam logic [FIELD_W-1:0] CODE_GPIO = 4'h0;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [ADDR_W-1:0] BANK2_GROUPC_UPPER_OFS = 8'h34;
  localparam logic [ADDR_W-1:0] BANK3_GROUPA_LOWER_OFS = 8'h40;
  localparam logic [ADDR_W-1:0] BANK3_GROUPA_UPPER_OFS = 8'h44;
  localparam logic [ADDR_W-1:0] BANK3_GROUPB_LOWER_OFS = 8'h48;
  localparam logic [ADDR_W-1:0] BANK3_GROUPB_UPPER_OFS = 8'h4c;
  localparam logic [ADDR_W-1:0] BANK3_GROUPC_LOWER_OFS = 8'h50;
  localparam logic [ADDR_W-1:0] BANK3_GROUPC_UPPER_OFS = 8'h54;
  localparam logic [ADDR_W-1:0] BANK3_GROUPD_LOWER_OFS = 8'h58;
  localparam logic [ADDR_W-1:0] UNROUTED_STATUS_OFS = 8'h80;

  localparam logic [ADDR_W-1:0] SEL_OFS [NUM_REGS] = '{
    BANK2_GROUPC_UPPER_OFS, BANK3_GROUPA_LOWER_OFS,
    BANK3_GROUPA_UPPER_OFS, BANK3_GROUPB_LOWER_OFS,
    BANK3_GROUPB_UPPER_OFS, BANK3_GROUPC_LOWER_OFS,
    BANK3_GROUPC_UPPER_OFS, BANK3_GROUPD_LOWER_OFS};

  // ****************************************************************
  // Listed codes per field: bit n set means code n is routed.
  // Index is register * 4 + field, field 0 at bits 3:0.
  // ****************************************************************
  localparam logic [15:0] LISTED_CODES [NUM_PADS] = '{
    // Bank 2 group C upper: c4, c5, c6, c7
    16'h0003, 16'h0007, 16'h0003, 16'h0001,
    // Bank 3 group A lower: a0, a1, a2, a3
    16'h0003, 16'h001f, 16'h001f, 16'h001f,
    // Bank 3 group A upper: a4, a5, a6, a7
    16'h0003, 16'h001f, 16'h0003, 16'h000f,
    // Bank 3 group B lower: b0, b1, b2, b3
    16'h000f, 16'h001f, 16'h0007, 16'h0007,
    // Bank 3 group B upper: b4, b5, b6, b7
    16'h001f, 16'h0007, 16'h001f, 16'h001f,
    // Bank 3 group C lower: c0, c1, c2, c3
    16'h0007, 16'h0007, 16'h000f, 16'h000f,
    // Bank 3 group C upper: c4, c5, c6, c7
    16'h000f, 16'h000f, 16'h000f, 16'h000f,
    // Bank 3 group D lower: d0, d1 are not decoded here
    16'hffff, 16'hffff, 16'h001f, 16'h001f};

  // ****************************************************************
  // Shared arithmetic
  // ****************************************************************
  function automatic logic [SEL_W-1:0] masked_update(
    input logic [SEL_W-1:0] old_val,
    input logic [DATA_W-1:0] word
  );
    logic [SEL_W-1:0] en;
    en = word[DATA_W-1:MASK_LSB];
    masked_update = (old_val & ~en) | (word[SEL_W-1:0] & en);
  endfunction

  function automatic logic [FIELD_W-1:0] field_of(
    input logic [SEL_W-1:0] val,
    input int unsigned n
  );
    field_of = val[n*FIELD_W +: FIELD_W];
  endfunction

endpackage

// ===== hw/sel_store_if.sv
`timescale 1ns/1ps
`default_nettype none

interface sel_store_if;
  import pin_select_pkg::*;

  logic wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [DATA_W-1:0] wr_word;
  logic rd_en;
  logic [IDX_W-1:0] rd_idx;
  logic [SEL_W-1:0] rd_word;
  logic [SEL_W-1:0] sel_codes [NUM_REGS];

  modport ctrl (
    output wr_en,
    output wr_idx,
    output wr_word,
    output rd_en,
    output rd_idx,
    input rd_word,
    input sel_codes
  );

  modport store (
    input wr_en,
    input wr_idx,
    input wr_word,
    input rd_en,
    input rd_idx,
    output rd_word,
    output sel_codes
  );
endinterface

`default_nettype wire

// ===== hw/select_store.sv
`timescale 1ns/1ps
`default_nettype none

module select_store
  import pin_select_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Access from the bus side
  sel_store_if.store port
);

  logic [SEL_W-1:0] sel_r [NUM_REGS];
  logic [SEL_W-1:0] rd_word_r;

  // ****************************************************************
  // Select words with bitwise write enable
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        sel_r[i] <= SEL_RESET;
    end
    else if (port.wr_en)
    begin
      // The upper half only steers this update and is never kept
      sel_r[port.wr_idx] <= masked_update(sel_r[port.wr_idx],
        port.wr_word);
    end
  end

  // Read data stand for one cycle only, zero otherwise
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rd_word_r <= SEL_RESET;
    else if (port.rd_en)
      rd_word_r <= sel_r[port.rd_idx];
    else
      rd_word_r <= SEL_RESET;
  end

  assign port.rd_word = rd_word_r;

  always_comb
  begin
    for (int i = 0; i < NUM_REGS; i++)
      port.sel_codes[i] = sel_r[i];
  end

endmodule

`default_nettype wire

// ===== hw/route_check.sv
`timescale 1ns/1ps
`default_nettype none

module route_check
  import pin_select_pkg::*;
#(
  parameter int unsigned REG_INDEX = 0
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Stored select word
  input wire logic [SEL_W-1:0] sel_word,
  // Per-field pad state
  output logic [FIELDS_PER_REG-1:0] gpio_mode_r,
  output logic [FIELDS_PER_REG-1:0] unrouted_r
);

  logic [FIELDS_PER_REG-1:0] gpio_mode_nxt;
  logic [FIELDS_PER_REG-1:0] unrouted_nxt;

  always_comb
  begin
    for (int f = 0; f < FIELDS_PER_REG; f++)
    begin
      gpio_mode_nxt[f] = field_of(sel_word, f) == CODE_GPIO;
      // An unlisted code is kept but reaches no peripheral
      unrouted_nxt[f] = !LISTED_CODES[REG_INDEX * FIELDS_PER_REG + f]
        [field_of(sel_word, f)];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gpio_mode_r <= '1;
      unrouted_r <= '0;
    end
    else
    begin
      gpio_mode_r <= gpio_mode_nxt;
      unrouted_r <= unrouted_nxt;
    end
  end

endmodule

`default_nettype wire

// ===== hw/pin_function_select_bank.sv
// Notes on behaviour
// - A written lower bit 0 changes only if bit 16 of the same word is one.
// - A lower bit whose mask bit is zero keeps its old value.
// - Every bit n of 15..0 is gated by written bit n+16, up to 31 for 15.
// - Bits 31:16 are a write-only enable, reset zero, never stored.
// - Four read-write 4-bit selects per word, reset zero, zero is GPIO.
// - Bank 2 group C upper: c7 GPIO only, c6/c5/c4 as listed.
// - Bank 3 group A lower: a3..a1 take codes 1..4, a0 code 1.
// - Bank 3 group A upper: a7/a5 codes 1..3, a5 code 4, a6/a4 code 1.
// - Bank 3 group B lower codes as listed per pin.
// - Bank 3 group B upper codes as listed per pin.
// - Bank 3 group C lower codes as listed per pin.
// - Bank 3 group C upper codes 1..3 on every pin.
// - Bank 3 group D lower: d3 and d2 take codes 1..4.
`timescale 1ns/1ps
`default_nettype none

module pin_function_select_bank
  import pin_select_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [pin_select_pkg::ADDR_W-1:0] addr,
  input wire logic [pin_select_pkg::DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [pin_select_pkg::DATA_W-1:0] rdata,
  // Bank 2 group C upper functions
  output logic [pin_select_pkg::FIELD_W-1:0] bank2_c7_function,
  output logic [pin_select_pkg::FIELD_W-1:0] bank2_c6_function,
  output logic [pin_select_pkg::FIELD_W-1:0] bank2_c5_function,
  output logic [pin_select_pkg::FIELD_W-1:0] bank2_c4_function,
  // Bank 3 group A functions
  output logic [pin_select_pkg::FIELD_W-1:0] bank3_a7_function,
  output logic [pin_select_pkg::FIELD_W-1:0] bank3_a6_function,
  output logic [pin_select_pkg::FIELD_W-1:0] bank3_a5_function,
  output logic [pin_select_pkg::FIELD_W-1:0] bank3_a4_function,
  output logic [pin_select_pkg::FIELD_W-1:0] bank3_a3_function,
  output logic [pin_select_pkg::FIELD_W-1:0] bank3_a2_function,
  output logic [pin_select_pkg::FIELD_W-1:0] bank3_a1_function,
  output logic [pin_select_pkg::FIELD_W-1:0] bank3_a0_function,
  // Bank 3 group B functions
  output logic [pin_select_pkg::FIELD_W-1:0] bank3_b7_function,
  output logic [pin_select_pkg::FIELD_W-1:0] bank3_b6_function,
  output logic [pin_select_pkg::FIELD_W-1:0] bank3_b5_function,
  output logic [pin_select_pkg::FIELD_W-1:0] bank3_b4_function,
  output logic [pin_select_pkg::FIELD_W-1:0] bank3_b3_function,
  output logic [pin_select_pkg::FIELD_W-1:0] bank3_b2_function,
  output logic [pin_select_pkg::FIELD_W-1:0] bank3_b1_function,
  output logic [pin_select_pkg::FIELD_W-1:0] bank3_b0_function,
  // Bank 3 group C functions
  output logic [pin_select_pkg::FIELD_W-1:0] bank3_c7_function,
  output logic [pin_select_pkg::FIELD_W-1:0] bank3_c6_function,
  output logic [pin_select_pkg::FIELD_W-1:0] bank3_c5_function,
  output logic [pin_select_pkg::FIELD_W-1:0] bank3_c4_function,
  output logic [pin_select_pkg::FIELD_W-1:0] bank3_c3_function,
  output logic [pin_select_pkg::FIELD_W-1:0] bank3_c2_function,
  output logic [pin_select_pkg::FIELD_W-1:0] bank3_c1_function,
  output logic [pin_select_pkg::FIELD_W-1:0] bank3_c0_function,
  // Bank 3 group D functions
  output logic [pin_select_pkg::FIELD_W-1:0] bank3_d3_function,
  output logic [pin_select_pkg::FIELD_W-1:0] bank3_d2_function,
  // Pad state, bit register*4+field
  output logic [pin_select_pkg::NUM_PADS-1:0] pad_gpio_mode,
  output logic [pin_select_pkg::NUM_PADS-1:0] pad_unrouted
);

  import pin_select_pkg::*;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic [IDX_W:0] decode_sel(
    input logic [ADDR_W-1:0] a
  );
    decode_sel = '0;
    for (int i = 0; i < NUM_REGS; i++)
    begin
      if (a == SEL_OFS[i])
        decode_sel = {1'b1, IDX_W'(i)};
    end
  endfunction

  sel_store_if store_bus ();

  logic [IDX_W:0] hit;
  logic status_rd_nxt;
  logic [DATA_W-1:0] status_rd_r;
  logic [SEL_W-1:0] codes [NUM_REGS];

  assign hit = decode_sel(addr);
  assign status_rd_nxt = rd_stb && (addr == UNROUTED_STATUS_OFS);

  // Unmapped writes are dropped, unmapped reads return zero
  assign store_bus.wr_en = wr_stb && hit[IDX_W];
  assign store_bus.wr_idx = hit[IDX_W-1:0];
  assign store_bus.wr_word = wdata;
  assign store_bus.rd_en = rd_stb && hit[IDX_W];
  assign store_bus.rd_idx = hit[IDX_W-1:0];

  select_store u_store (
    .clk(clk),
    .rstn(rstn),
    .port(store_bus.store)
  );

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      status_rd_r <= '0;
    else if (status_rd_nxt)
      status_rd_r <= pad_unrouted;
    else
      status_rd_r <= '0;
  end

  // Both sources are zero outside their read cycle, so OR merges them
  assign rdata = {16'h0000, store_bus.rd_word} | status_rd_r;

  // ****************************************************************
  // Pad routing
  // ****************************************************************
  always_comb
  begin
    for (int i = 0; i < NUM_REGS; i++)
      codes[i] = store_bus.sel_codes[i];
  end

  for (genvar g = 0; g < NUM_REGS; g++)
  begin : g_check
    route_check #(
      .REG_INDEX(g)
    ) u_check (
      .clk(clk),
      .rstn(rstn),
      .sel_word(codes[g]),
      .gpio_mode_r(pad_gpio_mode[g*FIELDS_PER_REG +: FIELDS_PER_REG]),
      .unrouted_r(pad_unrouted[g*FIELDS_PER_REG +: FIELDS_PER_REG])
    );
  end

  // Function codes come straight from the stored selects
  assign bank2_c7_function = field_of(codes[0], 3);
  assign bank2_c6_function = field_of(codes[0], 2);
  assign bank2_c5_function = field_of(codes[0], 1);
  assign bank2_c4_function = field_of(codes[0], 0);
  assign bank3_a3_function = field_of(codes[1], 3);
  assign bank3_a2_function = field_of(codes[1], 2);
  assign bank3_a1_function = field_of(codes[1], 1);
  assign bank3_a0_function = field_of(codes[1], 0);
  assign bank3_a7_function = field_of(codes[2], 3);
  assign bank3_a6_function = field_of(codes[2], 2);
  assign bank3_a5_function = field_of(codes[2], 1);
  assign bank3_a4_function = field_of(codes[2], 0);
  assign bank3_b3_function = field_of(codes[3], 3);
  assign bank3_b2_function = field_of(codes[3], 2);
  assign bank3_b1_function = field_of(codes[3], 1);
  assign bank3_b0_function = field_of(codes[3], 0);
  assign bank3_b7_function = field_of(codes[4], 3);
  assign bank3_b6_function = field_of(codes[4], 2);
  assign bank3_b5_function = field_of(codes[4], 1);
  assign bank3_b4_function = field_of(codes[4], 0);
  assign bank3_c3_function = field_of(codes[5], 3);
  assign bank3_c2_function = field_of(codes[5], 2);
  assign bank3_c1_function = field_of(codes[5], 1);
  assign bank3_c0_function = field_of(codes[5], 0);
  assign bank3_c7_function = field_of(codes[6], 3);
  assign bank3_c6_function = field_of(codes[6], 2);
  assign bank3_c5_function = field_of(codes[6], 1);
  assign bank3_c4_function = field_of(codes[6], 0);
  // Fields for d1 and d0 are stored and read back but drive no function output, only their pad flags
  assign bank3_d3_function = field_of(codes[7], 3);
  assign bank3_d2_function = field_of(codes[7], 2);

endmodule

`default_nettype wire

// ===== bench/pin_select_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module pin_select_assertions
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [31:0] rdata,
  // Watched pad functions and flags
  input wire logic [3:0] bank2_c7_function,
  input wire logic [3:0] bank3_a3_function,
  input wire logic [3:0] bank3_a2_function,
  input wire logic [3:0] bank3_a1_function,
  input wire logic [3:0] bank3_a0_function,
  input wire logic [3:0] bank3_c7_function,
  input wire logic [3:0] bank3_d3_function,
  input wire logic [31:0] pad_gpio_mode,
  input wire logic [31:0] pad_unrouted
);
  logic [15:0] a_lo;
  assign a_lo = {bank3_a3_function, bank3_a2_function,
                 bank3_a1_function, bank3_a0_function};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_rd_a;
    rd_stb && addr == 8'h40;
  endsequence
  sequence s_wr_a(logic [3:0] en);
    wr_stb && addr == 8'h40 && wdata[23:20] == en;
  endsequence

  a_mask_write: assert property (
    s_wr_a(4'hf) |=> {24'h0, bank3_a1_function, 4'h0} ==
      ($past(wdata) & 32'h0000_00f0))
    else $error("enabled field not written");
  a_mask_keep: assert property (
    s_wr_a(4'h0) |=> $stable(bank3_a1_function))
    else $error("disabled field changed");
  a_top_lane: assert property (
    wr_stb && addr == 8'h54 && wdata[31:28] == 4'hf |=>
      {16'h0, bank3_c7_function, 12'h0} == ($past(wdata) & 32'h0000_f000))
    else $error("top lane not written");
  // The status word at 0x80 is a full 32-bit map, so it is left out here
  a_mask_hidden: assert property (
    rd_stb && addr != 8'h80 |=> rdata[31:16] == 16'h0)
    else $error("enable half read back");
  a_gpio_flag: assert property (
    1'b1 |=> pad_gpio_mode[5] == ($past(bank3_a1_function) == 4'h0))
    else $error("gpio flag wrong");
  a_c7_unrouted: assert property (
    1'b1 |=> pad_unrouted[3] == ($past(bank2_c7_function) != 4'h0))
    else $error("gpio-only pad flag wrong");
  a_d3_unrouted: assert property (
    1'b1 |=> pad_unrouted[31] == ($past(bank3_d3_function) > 4'h4))
    else $error("d3 flag wrong");
  a_read_back: assert property (
    s_rd_a |=> rdata[15:0] == $past(a_lo))
    else $error("read data differs from selects");
  a_rdata_idle: assert property (
    !rd_stb |=> rdata == 32'h0)
    else $error("read data outside read cycle");
  a_stray_read: assert property (
    rd_stb && addr == 8'h3c ##1 1'b1 |-> rdata == 32'h0)
    else $error("unmapped read not zero");
endmodule

bind pin_function_select_bank pin_select_assertions u_chk (
  .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .bank2_c7_function(bank2_c7_function),
  .bank3_a3_function(bank3_a3_function),
  .bank3_a2_function(bank3_a2_function),
  .bank3_a1_function(bank3_a1_function),
  .bank3_a0_function(bank3_a0_function),
  .bank3_c7_function(bank3_c7_function),
  .bank3_d3_function(bank3_d3_function),
  .pad_gpio_mode(pad_gpio_mode), .pad_unrouted(pad_unrouted));

`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  import pin_select_pkg::*;

  // ********************************
  // Signals and expectations
  // ********************************
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [31:0] rdata, pad_gpio_mode, pad_unrouted, d;
  logic [3:0] bank2_c7_function, bank2_c6_function, bank2_c5_function;
  logic [3:0] bank2_c4_function, bank3_a7_function, bank3_a6_function;
  logic [3:0] bank3_a5_function, bank3_a4_function, bank3_a3_function;
  logic [3:0] bank3_a2_function, bank3_a1_function, bank3_a0_function;
  logic [3:0] bank3_b7_function, bank3_b6_function, bank3_b5_function;
  logic [3:0] bank3_b4_function, bank3_b3_function, bank3_b2_function;
  logic [3:0] bank3_b1_function, bank3_b0_function, bank3_c7_function;
  logic [3:0] bank3_c6_function, bank3_c5_function, bank3_c4_function;
  logic [3:0] bank3_c3_function, bank3_c2_function, bank3_c1_function;
  logic [3:0] bank3_c0_function, bank3_d3_function, bank3_d2_function;
  logic [127:0] fnv;
  logic [15:0] model [8];
  logic [31:0] exp_q [$];
  logic rd_d = 1'b0;
  int err_total = 0;
  int total_checks = 0;
  int r;
  int unsigned seed;
  // Highest listed code per pad; d1/d0 are never flagged
  localparam logic [127:0] MAX_CODE =
    128'h44ff_3333_3322_4424_2243_3141_4441_0121;

  assign fnv = {bank3_d3_function, bank3_d2_function, 8'h00,
    bank3_c7_function, bank3_c6_function, bank3_c5_function,
    bank3_c4_function, bank3_c3_function, bank3_c2_function,
    bank3_c1_function, bank3_c0_function, bank3_b7_function,
    bank3_b6_function, bank3_b5_function, bank3_b4_function,
    bank3_b3_function, bank3_b2_function, bank3_b1_function,
    bank3_b0_function, bank3_a7_function, bank3_a6_function,
    bank3_a5_function, bank3_a4_function, bank3_a3_function,
    bank3_a2_function, bank3_a1_function, bank3_a0_function,
    bank2_c7_function, bank2_c6_function, bank2_c5_function,
    bank2_c4_function};

  pin_function_select_bank u_dut (.*);

  always #2.5 clk = ~clk;

  // ********************************
  // Bus tasks and checks
  // ********************************
  task automatic cmp(logic [127:0] got, logic [127:0] e);
    total_checks++;
    if (got !== e)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask

  task automatic cyc(logic w, logic rr, logic [7:0] a, logic [31:0] dd);
    wr_stb <= w;
    rd_stb <= rr;
    addr <= a;
    wdata <= dd;
    @(posedge clk);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e);
    exp_q.push_back(e);
    cyc(1'b0, 1'b1, a, 32'h0);
  endtask

  task automatic wr(int k, logic [31:0] dd);
    model[k] = (model[k] & ~dd[31:16]) | (dd[15:0] & dd[31:16]);
    cyc(1'b1, 1'b0, SEL_OFS[k], dd);
  endtask

  function automatic logic [31:0] flags(bit g);
    logic [3:0] f;
    flags = '0;
    for (int i = 0; i < 32; i++)
    begin
      f = model[i / 4][(i % 4) * 4 +: 4];
      flags[i] = g ? (f == 4'h0) : (f > MAX_CODE[i * 4 +: 4]);
    end
  endfunction

  // Pad flags trail the selects by one edge, so wait two
  task automatic settle();
    cyc(1'b0, 1'b0, 8'h00, 32'h0);
    cyc(1'b0, 1'b0, 8'h00, 32'h0);
    cmp(pad_gpio_mode | 32'h3000_0000, flags(1) | 32'h3000_0000);
    cmp(pad_unrouted, flags(0));
    cmp(fnv, {model[7] & 16'hff00, model[6], model[5], model[4],
      model[3], model[2], model[1], model[0]});
    rd(8'h80, flags(0));
  endtask

  task automatic test_done();
    if (err_total == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk)
  begin
    if (rd_d)
      cmp(rdata, exp_q.pop_front());
    rd_d <= rd_stb;
  end

  initial
  begin
    #100000;
    err_total++;
    test_done();
  end

  initial
  begin
    seed = $urandom(41);
    for (int k = 0; k < 8; k++)
      model[k] = 16'h0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 8; k++)
      rd(SEL_OFS[k], 32'h0);
    settle();
    // Every code on every pad of every word
    for (int k = 0; k < 8; k++)
      for (int c = 0; c < 16; c++)
      begin
        wr(k, {16'hffff, {4{c[3:0]}}});
        settle();
      end
    // Random masks, each write read back at once
    for (int n = 0; n < 200; n++)
    begin
      r = $urandom_range(7);
      d = $urandom;
      if (n < 2)
      begin
        r = 1;
        d[31:16] = n ? 16'h0000 : 16'h8001;
      end
      wr(r, d);
      rd(SEL_OFS[r], {16'h0, model[r]});
    end
    settle();
    // Unmapped places and the read-only status word
    cyc(1'b1, 1'b0, 8'h3c, 32'hffff_ffff);
    cyc(1'b1, 1'b0, 8'h80, 32'hffff_ffff);
    rd(8'h3c, 32'h0);
    rd(8'h00, 32'h0);
    settle();
    // Reset in mid-run clears every select
    cyc(1'b0, 1'b0, 8'h00, 32'h0);
    cyc(1'b0, 1'b0, 8'h00, 32'h0);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (int k = 0; k < 8; k++)
      model[k] = 16'h0;
    @(posedge clk);
    settle();
    rd(SEL_OFS[7], 32'h0);
    cyc(1'b0, 1'b0, 8'h00, 32'h0);
    cyc(1'b0, 1'b0, 8'h00, 32'h0);
    test_done();
  end
endmodule

`default_nettype wire
